// ---- hdl/fbt_unit.sv ----
// Bitwise test unit with optional result write-back and an AXI4-Lite register port
`timescale 1ns/1ps
`default_nettype none
`include "fbt_defines.svh"

// Notes on behaviour
// - Opcode 011000 runs the plain test, destination AND source, over 4 clock cycles.
// - Opcode 011001 runs the inverted test, destination AND NOT source, over 4 clock cycles.
// - The inverted test complements the source before the AND.
// - The source is the source register or a 9-bit immediate, chosen by the immediate bit.
// - Without the write-result bit the destination is left alone and only the flags and the result register may change.
// - With the zero effect bit the zero flag becomes 1 exactly when the result is zero.
// - With the carry effect bit the carry flag becomes the odd parity of the result.
// - The result reaches the destination only when the write-result bit is set.
// - The plain test with write-result stores the AND result like an ordinary AND.
// - The inverted test with write-result stores the AND-with-complement result.
module fbt_unit
   import fbt_pkg::*;
(
   // Clock and reset
   input  wire logic        aclk,
   input  wire logic        aresetn,
   // Write address channel
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   // Write data channel
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   // Write response channel
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   // Read address channel
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   // Read data channel
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   // Core state
   output logic             zero_flag,
   output logic             carry_flag,
   output logic             busy
);

   function automatic fbt_word_t fbt_merge(input fbt_word_t old_v,
                                           input fbt_word_t new_v,
                                           input logic [3:0] strb);
      fbt_word_t m;
      m = old_v;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            m[i*8 +: 8] = new_v[i*8 +: 8];
         end
      end
      return m;
   endfunction

   fbt_state_e  state_r;
   fbt_state_e  state_nxt;
   logic [2:0]  cnt_r;
   fbt_word_t   dval_r;
   fbt_word_t   sval_r;
   fbt_word_t   instr_r;
   fbt_word_t   result_r;
   logic        zero_r;
   logic        carry_r;
   logic        err_r;
   logic [7:0]  awaddr_r;
   fbt_word_t   wdata_r;
   logic [3:0]  wstrb_r;
   logic        awready_r;
   logic        wready_r;
   logic        bvalid_r;
   logic [1:0]  bresp_r;
   logic        arready_r;
   logic        rvalid_r;
   fbt_word_t   rdata_r;
   logic [1:0]  rresp_r;

   // Operand selection and logic result
   wire logic [5:0] op_w     = instr_r[`FBT_OP_HI:`FBT_OP_LO];
   wire logic       zeff_w   = instr_r[`FBT_BIT_ZEFF];
   wire logic       ceff_w   = instr_r[`FBT_BIT_CEFF];
   wire logic       reff_w   = instr_r[`FBT_BIT_REFF];
   wire logic       imm_w    = instr_r[`FBT_BIT_IMM];
   wire fbt_imm_t   imm_val  = instr_r[`FBT_SRC_HI:`FBT_SRC_LO];
   wire fbt_word_t  imm_ext  = {23'h000000, imm_val};
   wire fbt_word_t  src_op   = imm_w ? imm_ext : sval_r;
   wire logic       inv_w    = (op_w == `FBT_OP_INVERT);
   wire fbt_word_t  src_eff  = inv_w ? ~src_op : src_op;
   wire fbt_word_t  res_w    = dval_r & src_eff;
   wire logic       res_zero = (res_w == 32'h00000000);
   wire logic       res_par  = ^res_w;
   wire logic       commit   = (state_r == FBT_EXEC) && (cnt_r == 3'h0);

   // Write path decode
   wire logic       wr_go    = !awready_r && !wready_r && !bvalid_r;
   wire logic       is_dval  = (awaddr_r == `FBT_OFF_DVAL);
   wire logic       is_sval  = (awaddr_r == `FBT_OFF_SVAL);
   wire logic       is_instr = (awaddr_r == `FBT_OFF_INSTR);
   wire logic       is_stat  = (awaddr_r == `FBT_OFF_STATUS);
   wire logic       is_res   = (awaddr_r == `FBT_OFF_RESULT);
   wire logic       mapped   = is_dval || is_sval || is_instr || is_stat || is_res;
   wire logic       idle_w   = (state_r == FBT_IDLE);
   wire fbt_word_t  new_ins  = fbt_merge(instr_r, wdata_r, wstrb_r);
   wire logic [5:0] new_op   = new_ins[`FBT_OP_HI:`FBT_OP_LO];
   wire logic       op_ok    = (new_op == `FBT_OP_PLAIN) || (new_op == `FBT_OP_INVERT);
   wire logic       refuse   = !mapped || is_res || (!idle_w && !is_stat)
                               || (is_instr && !op_ok);
   wire logic       wr_ok    = wr_go && !refuse;
   wire logic       start    = wr_ok && is_instr;
   wire logic       err_clr  = wr_ok && is_stat && wstrb_r[0] && wdata_r[`FBT_ST_ERR];
   wire logic       err_set  = wr_go && refuse;

   // Read path decode
   wire fbt_word_t  status_w = {28'h0000000, err_r, carry_r, zero_r, !idle_w};
   wire logic       ar_ok    = (s_axi_araddr == `FBT_OFF_DVAL)
                               || (s_axi_araddr == `FBT_OFF_SVAL)
                               || (s_axi_araddr == `FBT_OFF_INSTR)
                               || (s_axi_araddr == `FBT_OFF_STATUS)
                               || (s_axi_araddr == `FBT_OFF_RESULT);
   wire fbt_word_t  rd_mux   = (s_axi_araddr == `FBT_OFF_DVAL)   ? dval_r   :
                               (s_axi_araddr == `FBT_OFF_SVAL)   ? sval_r   :
                               (s_axi_araddr == `FBT_OFF_INSTR)  ? instr_r  :
                               (s_axi_araddr == `FBT_OFF_STATUS) ? status_w :
                               (s_axi_araddr == `FBT_OFF_RESULT) ? result_r :
                               `FBT_RST_WORD;
   wire logic       rd_take  = s_axi_arvalid && arready_r;

   // Execution sequencer
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         FBT_IDLE: begin
            if (start) begin
               state_nxt = FBT_EXEC;
            end
         end
         FBT_EXEC: begin
            if (cnt_r == 3'h0) begin
               state_nxt = FBT_IDLE;
            end
         end
         default: begin
            state_nxt = FBT_IDLE;
         end
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_r <= FBT_IDLE;
         cnt_r   <= 3'h0;
      end else begin
         state_r <= state_nxt;
         cnt_r   <= start ? `FBT_CNT_LOAD : (cnt_r != 3'h0 ? cnt_r - 3'h1 : 3'h0);
      end
   end

   // Operand and instruction registers
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         dval_r  <= `FBT_RST_WORD;
         sval_r  <= `FBT_RST_WORD;
         instr_r <= `FBT_RST_WORD;
      end else begin
         if (commit && reff_w) begin
            dval_r <= res_w;
         end else if (wr_ok && is_dval) begin
            dval_r <= fbt_merge(dval_r, wdata_r, wstrb_r);
         end
         if (wr_ok && is_sval) begin
            sval_r <= fbt_merge(sval_r, wdata_r, wstrb_r);
         end
         if (start) begin
            instr_r <= new_ins;
         end
      end
   end

   // Flags and result capture
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         zero_r   <= 1'b0;
         carry_r  <= 1'b0;
         err_r    <= 1'b0;
         result_r <= `FBT_RST_WORD;
      end else begin
         if (commit) begin
            result_r <= res_w;
         end
         if (commit && zeff_w) begin
            zero_r <= res_zero;
         end
         if (commit && ceff_w) begin
            carry_r <= res_par;
         end
         err_r <= err_set || (err_r && !err_clr);
      end
   end

   // Write channels
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         awready_r <= 1'b1;
         wready_r  <= 1'b1;
         bvalid_r  <= 1'b0;
         bresp_r   <= `FBT_RESP_OKAY;
         awaddr_r  <= 8'h00;
         wdata_r   <= `FBT_RST_WORD;
         wstrb_r   <= 4'h0;
      end else begin
         if (s_axi_awvalid && awready_r) begin
            awready_r <= 1'b0;
            awaddr_r  <= s_axi_awaddr;
         end
         if (s_axi_wvalid && wready_r) begin
            wready_r <= 1'b0;
            wdata_r  <= s_axi_wdata;
            wstrb_r  <= s_axi_wstrb;
         end
         if (wr_go) begin
            bvalid_r <= 1'b1;
            bresp_r  <= refuse ? `FBT_RESP_SLVERR : `FBT_RESP_OKAY;
         end else if (bvalid_r && s_axi_bready) begin
            bvalid_r  <= 1'b0;
            awready_r <= 1'b1;
            wready_r  <= 1'b1;
         end
      end
   end

   // Read channels
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready_r <= 1'b1;
         rvalid_r  <= 1'b0;
         rdata_r   <= `FBT_RST_WORD;
         rresp_r   <= `FBT_RESP_OKAY;
      end else begin
         if (rd_take) begin
            arready_r <= 1'b0;
            rvalid_r  <= 1'b1;
            rdata_r   <= rd_mux;
            rresp_r   <= ar_ok ? `FBT_RESP_OKAY : `FBT_RESP_SLVERR;
         end else if (rvalid_r && s_axi_rready) begin
            rvalid_r  <= 1'b0;
            arready_r <= 1'b1;
         end
      end
   end

   assign s_axi_awready = awready_r;
   assign s_axi_wready  = wready_r;
   assign s_axi_bvalid  = bvalid_r;
   assign s_axi_bresp   = bresp_r;
   assign s_axi_arready = arready_r;
   assign s_axi_rvalid  = rvalid_r;
   assign s_axi_rdata   = rdata_r;
   assign s_axi_rresp   = rresp_r;
   assign zero_flag     = zero_r;
   assign carry_flag    = carry_r;
   assign busy          = (state_r == FBT_EXEC);

   // Checks
   a_exec_four_cycles: assert property (
      @(posedge aclk) disable iff (!aresetn)
      $rose(state_r == FBT_EXEC) |-> (state_r == FBT_EXEC) [*4] ##1 (state_r == FBT_IDLE))
      else $error("execution did not last four cycles");

   a_invert_exec_len: assert property (
      @(posedge aclk) disable iff (!aresetn)
      (start && new_op == `FBT_OP_INVERT) |=> busy ##3 commit ##1 !busy)
      else $error("inverted test did not complete in four cycles");

   a_src_inverted: assert property (
      @(posedge aclk) disable iff (!aresetn)
      (busy && inv_w) |-> (res_w == (dval_r & ~(imm_w ? {23'h000000, instr_r[8:0]} : sval_r))))
      else $error("inverted test did not complement the source");

   a_src_select: assert property (
      @(posedge aclk) disable iff (!aresetn)
      busy |-> (src_op == (imm_w ? {23'h000000, instr_r[8:0]} : sval_r)))
      else $error("source operand selection wrong");

   a_dest_untouched: assert property (
      @(posedge aclk) disable iff (!aresetn)
      (commit && !reff_w) |=> $stable(dval_r))
      else $error("destination changed without write-result");

   a_zero_update: assert property (
      @(posedge aclk) disable iff (!aresetn)
      (commit && zeff_w) |=> (zero_flag == ($past(res_w) == 32'h00000000)))
      else $error("zero flag not set from result");

   a_carry_parity: assert property (
      @(posedge aclk) disable iff (!aresetn)
      (commit && ceff_w) |=> (carry_flag == ^$past(res_w)))
      else $error("carry flag not parity of result");

   a_flags_hold: assert property (
      @(posedge aclk) disable iff (!aresetn)
      (commit && !zeff_w && !ceff_w) |=> $stable(zero_flag) && $stable(carry_flag))
      else $error("flag changed without its effect bit");

   a_dest_written: assert property (
      @(posedge aclk) disable iff (!aresetn)
      (commit && reff_w) |=> (dval_r == $past(res_w)))
      else $error("destination not written with result");

   a_plain_and: assert property (
      @(posedge aclk) disable iff (!aresetn)
      (busy && op_w == `FBT_OP_PLAIN)
         |-> (res_w == (dval_r & (imm_w ? {23'h000000, instr_r[8:0]} : sval_r))))
      else $error("plain test is not an AND");

   a_busy_no_start: assert property (
      @(posedge aclk) disable iff (!aresetn)
      busy |-> !start)
      else $error("instruction started while busy");

   a_result_capture: assert property (
      @(posedge aclk) disable iff (!aresetn)
      commit |=> (result_r == $past(res_w)))
      else $error("result register not loaded at completion");

   a_and_with_complement_op_store: assert property (
      @(posedge aclk) disable iff (!aresetn)
      (commit && reff_w && inv_w) |=> (dval_r == ($past(dval_r) & ~$past(src_op))))
      else $error("inverted test stored wrong value");

   a_imm_zero_ext: assert property (
      @(posedge aclk) disable iff (!aresetn)
      (busy && imm_w) |-> (src_op[31:9] == 23'h000000))
      else $error("immediate not zero-extended");

endmodule
`default_nettype wire

// ---- hdl/fbt_defines.svh ----
// Offsets, field positions, reset values and timing counts of the bitwise test unit
`ifndef FBT_DEFINES_SVH
`define FBT_DEFINES_SVH

`define FBT_OFF_DVAL     8'h00
`define FBT_OFF_SVAL     8'h04
`define FBT_OFF_INSTR    8'h08
`define FBT_OFF_STATUS   8'h0C
`define FBT_OFF_RESULT   8'h10

`define FBT_OP_HI        31
`define FBT_OP_LO        26
`define FBT_BIT_ZEFF     25
`define FBT_BIT_CEFF     24
`define FBT_BIT_REFF     23
`define FBT_BIT_IMM      22
`define FBT_SRC_HI       8
`define FBT_SRC_LO       0

`define FBT_OP_PLAIN     6'h18
`define FBT_OP_INVERT    6'h19

`define FBT_ST_BUSY      0
`define FBT_ST_ZERO      1
`define FBT_ST_CARRY     2
`define FBT_ST_ERR       3

`define FBT_RST_WORD     32'h00000000
`define FBT_EXEC_CYCLES  3'h4
`define FBT_CNT_LOAD     3'h3

`define FBT_RESP_OKAY    2'h0
`define FBT_RESP_SLVERR  2'h2

`endif

// ---- hdl/fbt_pkg.sv ----
// Types shared by the bitwise test unit
package fbt_pkg;
   typedef logic [31:0] fbt_word_t;
   typedef logic [8:0]  fbt_imm_t;
   typedef enum logic [0:0] {
      FBT_IDLE = 1'b0,
      FBT_EXEC = 1'b1
   } fbt_state_e;
endpackage

// ---- testbench/fbt_unit_tb_top.sv ----
// Self-checking testbench of the bitwise test unit with optional result write-back
`timescale 1ns/1ps
`default_nettype none
`include "fbt_defines.svh"
module fbt_unit_tb_top
   import fbt_pkg::*;
;
   localparam logic [1:0] OK    = `FBT_RESP_OKAY;
   localparam logic [1:0] ER    = `FBT_RESP_SLVERR;
   localparam logic [5:0] PL    = `FBT_OP_PLAIN;
   localparam logic [5:0] IV    = `FBT_OP_INVERT;
   localparam int         LIMIT = 4000;
   logic        aclk;
   logic        aresetn;
   logic [7:0]  awaddr;
   logic [7:0]  araddr;
   logic [31:0] wdata;
   logic [31:0] rdata;
   logic [3:0]  wstrb;
   logic [1:0]  bresp;
   logic [1:0]  rresp;
   logic        awvalid, awready, wvalid, wready, bvalid, bready;
   logic        arvalid, arready, rvalid, rready;
   logic        zero_flag, carry_flag, busy;
   logic        exp_z, exp_c;
   int          num_errors;
   int          num_checks;
   int          cycles = 0;

   fbt_unit u_fbt_unit (
      .aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .zero_flag(zero_flag), .carry_flag(carry_flag), .busy(busy)
   );

   initial begin
      aclk = 1'b0;
      forever #12.5 aclk = ~aclk;
   end

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic end_of_test();
      $display("checks %0d errors %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   // Write one word; address and data offered together
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er,
                     input logic [3:0] s = 4'hF);
      logic ad;
      logic wd;
      ad = 1'b0;
      wd = 1'b0;
      @(posedge aclk);
      awaddr  <= a;
      awvalid <= 1'b1;
      wdata   <= d;
      wstrb   <= s;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      while (!(ad && wd)) begin
         @(posedge aclk);
         if (!ad && awready === 1'b1) begin
            ad = 1'b1;
            awvalid <= 1'b0;
         end
         if (!wd && wready === 1'b1) begin
            wd = 1'b1;
            wvalid <= 1'b0;
         end
      end
      while (bvalid !== 1'b1) @(posedge aclk);
      chk(32'(bresp), 32'(er));
      bready <= 1'b0;
   endtask

   // Read one word and compare data and response
   task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
      @(posedge aclk);
      araddr  <= a;
      arvalid <= 1'b1;
      rready  <= 1'b1;
      do @(posedge aclk); while (arready !== 1'b1);
      arvalid <= 1'b0;
      while (rvalid !== 1'b1) @(posedge aclk);
      chk(32'(rresp), 32'(er));
      chk(rdata, ed);
      rready <= 1'b0;
   endtask

   function automatic fbt_word_t mk(input logic [5:0] op, input logic [3:0] zcri,
                                    input fbt_imm_t imm);
      return {op, zcri, 13'h0, imm};
   endfunction

   // Load operands, run one instruction, judge timing, flags and registers
   task automatic run_op(input fbt_word_t d, input fbt_word_t s, input fbt_word_t ins);
      fbt_word_t src;
      fbt_word_t res;
      int        n;
      src = ins[`FBT_BIT_IMM] ? {23'h0, ins[`FBT_SRC_HI:`FBT_SRC_LO]} : s;
      res = (ins[`FBT_OP_HI:`FBT_OP_LO] == IV) ? (d & ~src) : (d & src);
      if (ins[`FBT_BIT_ZEFF]) exp_z = (res == 32'h0);
      if (ins[`FBT_BIT_CEFF]) exp_c = ^res;
      wr(`FBT_OFF_DVAL, d, OK);
      wr(`FBT_OFF_SVAL, s, OK);
      wr(`FBT_OFF_INSTR, ins, OK);
      n = 0;
      while (busy === 1'b1) begin
         n++;
         @(posedge aclk);
      end
      chk(32'(n), 32'h4);
      chk(32'(zero_flag), 32'(exp_z));
      chk(32'(carry_flag), 32'(exp_c));
      rd(`FBT_OFF_RESULT, res, OK);
      rd(`FBT_OFF_DVAL, ins[`FBT_BIT_REFF] ? res : d, OK);
   endtask

   task automatic t_reset();
      chk(32'({zero_flag, carry_flag, busy}), 32'h0);
      for (int i = 0; i < 5; i++) rd(8'(i * 4), 32'h0, OK);
      rd(8'h14, 32'h0, ER);
      wr(`FBT_OFF_DVAL, 32'hAABBCCDD, OK);
      wr(`FBT_OFF_DVAL, 32'h11223344, OK, 4'h5);
      rd(`FBT_OFF_DVAL, 32'hAA22CC44, OK);
      $display("test reset done");
   endtask

   task automatic t_plain();
      run_op(32'h0000000A, 32'h00000005, mk(PL, 4'hC, 9'h0));
      run_op(32'h00000003, 32'h00000001, mk(PL, 4'h0, 9'h0));
      run_op(32'h0000000A, 32'h00000007, mk(PL, 4'hC, 9'h0));
      run_op(32'h0000000A, 32'h0000000F, mk(PL, 4'hE, 9'h0));
      $display("test plain done");
   endtask

   task automatic t_invert();
      run_op(32'hF731125A, 32'hFFFFFFFA, mk(IV, 4'hE, 9'h0));
      run_op(32'hF731125A, 32'hFFFFFFF8, mk(IV, 4'hE, 9'h0));
      run_op(32'hF731125A, 32'hFFFFFFF0, mk(IV, 4'hC, 9'h0));
      $display("test invert done");
   endtask

   task automatic t_imm();
      run_op(32'hFFFFFFFF, 32'h12345678, mk(PL, 4'hF, 9'h1FF));
      run_op(32'hFFFFFFFF, 32'h12345678, mk(IV, 4'hB, 9'h0F0));
      $display("test immediate done");
   endtask

   task automatic t_refuse();
      wr(`FBT_OFF_INSTR, mk(6'h1A, 4'hC, 9'h0), ER);
      rd(`FBT_OFF_STATUS, {28'h0, 1'b1, exp_c, exp_z, 1'b0}, OK);
      wr(`FBT_OFF_STATUS, 32'h8, OK);
      rd(`FBT_OFF_STATUS, {28'h0, 1'b0, exp_c, exp_z, 1'b0}, OK);
      wr(`FBT_OFF_RESULT, 32'h1, ER);
      wr(8'h20, 32'h1, ER);
      wr(`FBT_OFF_DVAL, 32'h6, OK);
      wr(`FBT_OFF_SVAL, 32'h3, OK);
      wr(`FBT_OFF_INSTR, mk(PL, 4'h2, 9'h0), OK);
      wr(`FBT_OFF_DVAL, 32'h77, ER);
      while (busy === 1'b1) @(posedge aclk);
      rd(`FBT_OFF_DVAL, 32'h2, OK);
      chk(32'({zero_flag, carry_flag}), 32'({exp_z, exp_c}));
      $display("test refusal done");
   endtask

   always @(posedge aclk) begin
      cycles <= cycles + 1;
      if (cycles == LIMIT) begin
         num_errors++;
         end_of_test();
      end
   end

   initial begin
      num_errors = 0;
      num_checks = 0;
      exp_z = 1'b0;
      exp_c = 1'b0;
      aresetn <= 1'b0;
      awaddr  <= 8'h00;
      awvalid <= 1'b0;
      wdata   <= 32'h00000000;
      wstrb   <= 4'hF;
      wvalid  <= 1'b0;
      bready  <= 1'b0;
      araddr  <= 8'h00;
      arvalid <= 1'b0;
      rready  <= 1'b0;
      repeat (20) @(posedge aclk);
      aresetn <= 1'b1;
      t_reset();
      t_plain();
      t_invert();
      t_imm();
      t_refuse();
      end_of_test();
   end
endmodule
`default_nettype wire
